// *** paged_word.sv ***
// One paged 16-bit command word with optional staged copy
`timescale 1ns/1ps
`default_nettype none
module paged_word #(
    parameter logic [15:0] RESET_VALUE = 16'h0000
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        commit,
    output logic      [15:0] held,
    output logic      [15:0] live
);
    logic [15:0] held_reg;
    logic [15:0] held_next;
    logic [15:0] live_reg;
    logic [15:0] live_next;

    always_comb begin
        held_next = wr_en ? wr_data : held_reg;
        live_next = commit ? held_reg : live_reg;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            held_reg <= RESET_VALUE;
            live_reg <= RESET_VALUE;
        end else begin
            held_reg <= held_next;
            live_reg <= live_next;
        end
    end

    assign held = held_reg;
    assign live = live_reg;
endmodule : paged_word
`default_nettype wire

// *** pmbus_host_model.sv ***
// Behavioural management-bus host driving the command strobes of the bank
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    input  wire logic        cmd_unsupported,
    output logic             page,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    output logic             commit_pending_config
);
    initial begin
        page = 1'b0;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h5555;
        commit_pending_config = 1'b0;
    end
    // One 16-bit word per access; strobe held for exactly one rising edge
    task automatic access(input logic wr, input logic pg, input logic [7:0] code, input logic [15:0] data,
                          output logic [15:0] rdata, output logic valid, output logic unsup);
        @(negedge mclk);
        page = pg;
        cmd_code = code;
        cmd_wdata = data;
        cmd_wr = wr;
        cmd_rd = !wr;
        @(negedge mclk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        rdata = cmd_rdata;
        valid = cmd_rvalid;
        unsup = cmd_unsupported;
        // Released bus shows the inverse so a stale word never looks valid
        cmd_wdata = ~data;
        cmd_code = ~code;
    endtask : access
    task automatic commit();
        @(negedge mclk);
        commit_pending_config = 1'b1;
        @(negedge mclk);
        commit_pending_config = 1'b0;
    endtask : commit
endmodule : pmbus_host_model
`default_nettype wire

// *** target_clamp.sv ***
// Selects the operating target and saturates it to the floor/ceiling window
`timescale 1ns/1ps
`default_nettype none
module target_clamp (
    input  wire logic [1:0]  op_sel,
    input  wire logic [15:0] nominal,
    input  wire logic [15:0] marg_hi,
    input  wire logic [15:0] marg_lo,
    input  wire logic [15:0] floor_v,
    input  wire logic [15:0] ceiling_v,
    output logic      [15:0] target
);
    logic [15:0] chosen;

    always_comb begin
        unique case (op_sel)
            vout_bank_pkg::OP_MARG_HI: chosen = marg_hi;
            vout_bank_pkg::OP_MARG_LO: chosen = marg_lo;
            default:                   chosen = nominal;
        endcase
        // ceiling wins if floor exceeds it
        if (chosen > ceiling_v) begin
            target = ceiling_v;
        end else if (chosen < floor_v) begin
            target = (floor_v > ceiling_v) ? ceiling_v : floor_v;
        end else begin
            target = chosen;
        end
    end
endmodule : target_clamp
`default_nettype wire

// *** test_vout_limit_margin_command_bank.sv ***
// Self-checking bench for the paged output-target command bank
`timescale 1ns/1ps
`default_nettype none
module test_vout_limit_margin_command_bank;
    typedef struct packed {logic pg; logic [7:0] code; logic [15:0] data;} row_s;
    logic        mclk = 1'b0, reset = 1'b1;
    logic [1:0]  op_sel_0 = 2'h0, op_sel_1 = 2'h0;
    logic [15:0] vout_sense_0 = 16'h0000, vout_sense_1 = 16'h0000;
    logic        page, cmd_wr, cmd_rd, commit_pending_config, cmd_rvalid, cmd_unsupported, ov_fault_0, ov_fault_1;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, vref_target_0, vref_target_1, slew_rate_0, slew_rate_1;
    logic [15:0] droop_slope_0, droop_slope_1, rd_data;
    logic        rd_valid, rd_unsup;
    int          n_fail = 0, comparisons = 0;
    localparam logic [7:0]  codes [8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2B, 8'h40, 8'h21};
    localparam logic [15:0] dflt [8] = '{16'h08FC, 16'h0640, 16'h00FA, 16'h0064, 16'h0000, 16'h0000,
                                         16'h076C, 16'h0384};
    localparam row_s rows [10] = '{'{1'b0, 8'h24, 16'h0CE4}, '{1'b1, 8'h24, 16'h0500}, '{1'b0, 8'h25, 16'h0700},
        '{1'b1, 8'h25, 16'h0600}, '{1'b0, 8'h26, 16'h0100}, '{1'b1, 8'h2B, 16'h0200}, '{1'b0, 8'h27, 16'h00C8},
        '{1'b0, 8'h28, 16'h0010}, '{1'b1, 8'h40, 16'h0400}, '{1'b1, 8'h28, 16'h0020}};
    always #2 mclk = ~mclk;
    vout_limit_margin_command_bank u_dut (.mclk, .reset, .page, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
        .commit_pending_config, .op_sel_0, .op_sel_1, .vout_sense_0, .vout_sense_1, .cmd_rdata, .cmd_rvalid,
        .cmd_unsupported, .vref_target_0, .vref_target_1, .slew_rate_0, .slew_rate_1, .droop_slope_0,
        .droop_slope_1, .ov_fault_0, .ov_fault_1);
    pmbus_host_model u_host (.mclk, .cmd_rdata, .cmd_rvalid, .cmd_unsupported, .page, .cmd_wr, .cmd_rd,
        .cmd_code, .cmd_wdata, .commit_pending_config);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic pg, input logic [7:0] code, input logic [15:0] data);
        u_host.access(1'b1, pg, code, data, rd_data, rd_valid, rd_unsup);
    endtask : wr
    task automatic rd_check(input logic pg, input logic [7:0] code, input logic [15:0] exp);
        u_host.access(1'b0, pg, code, 16'h0000, rd_data, rd_valid, rd_unsup);
        check({14'h0000, rd_valid, rd_unsup}, 16'h0002);
        check(rd_data, exp);
    endtask : rd_check
    task automatic check_defaults();
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 8; i++)
                rd_check(p[0], codes[i], dflt[i]);
    endtask : check_defaults
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask : settle
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        #40000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        check(vref_target_0, 16'h0384);
        check(slew_rate_1, 16'h0064);
        check(droop_slope_0, 16'h0000);
        check_defaults();
        foreach (rows[i]) begin
            wr(rows[i].pg, rows[i].code, rows[i].data);
            rd_check(rows[i].pg, rows[i].code, rows[i].data);
        end
        rd_check(1'b0, 8'h24, 16'h0CE4);
        // Staged values must not reach the live outputs before the commit
        vout_sense_0 = 16'h076D;
        vout_sense_1 = 16'h0500;
        settle();
        check(slew_rate_0, 16'h0064);
        check(droop_slope_0, 16'h0000);
        check(droop_slope_1, 16'h0000);
        check({15'h0000, ov_fault_1}, 16'h0000);
        check({15'h0000, ov_fault_0}, 16'h0001);
        vout_sense_0 = 16'h076C;
        settle();
        check({15'h0000, ov_fault_0}, 16'h0000);
        u_host.commit();
        repeat (3) @(negedge mclk);
        check(slew_rate_0, 16'h00C8);
        check(droop_slope_0, 16'h0010);
        check(slew_rate_1, 16'h0064);
        check(droop_slope_1, 16'h0020);
        check({15'h0000, ov_fault_1}, 16'h0001);
        op_sel_0 = 2'h2;
        op_sel_1 = 2'h2;
        settle();
        check(vref_target_0, 16'h0700);
        check(vref_target_1, 16'h0500);
        op_sel_0 = 2'h1;
        op_sel_1 = 2'h1;
        settle();
        check(vref_target_0, 16'h0100);
        check(vref_target_1, 16'h0200);
        wr(1'b0, 8'h24, 16'h0080);
        settle();
        check(vref_target_0, 16'h0080);
        op_sel_0 = 2'h3;
        wr(1'b0, 8'h21, 16'h0050);
        settle();
        check(vref_target_0, 16'h0050);
        // Floor above ceiling: the ceiling must win
        wr(1'b0, 8'h2B, 16'h0100);
        settle();
        check(vref_target_0, 16'h0080);
        u_host.access(1'b0, 1'b0, 8'h22, 16'h0000, rd_data, rd_valid, rd_unsup);
        check({14'h0000, rd_valid, rd_unsup}, 16'h0001);
        check(rd_data, 16'h0CE4);
        wr(1'b1, 8'h41, 16'h1234);
        check({15'h0000, rd_unsup}, 16'h0001);
        // Second reset in mid-run restores every default
        @(negedge mclk);
        reset = 1'b1;
        @(negedge mclk);
        check(slew_rate_0, 16'h0064);
        reset = 1'b0;
        check_defaults();
        conclude();
    end
endmodule : test_vout_limit_margin_command_bank
`default_nettype wire

// *** vout_bank_pkg.sv ***
// Constants for the paged output-target command bank
package vout_bank_pkg;
    localparam int          PAGES       = 2;
    localparam int          CMD_W       = 8;
    localparam int          DATA_W      = 16;
    // Command codes
    localparam logic [7:0]  CMD_CEILING = 8'h24;
    localparam logic [7:0]  CMD_MARG_HI = 8'h25;
    localparam logic [7:0]  CMD_MARG_LO = 8'h26;
    localparam logic [7:0]  CMD_SLEW    = 8'h27;
    localparam logic [7:0]  CMD_DROOP   = 8'h28;
    localparam logic [7:0]  CMD_FLOOR   = 8'h2B;
    localparam logic [7:0]  CMD_OV      = 8'h40;
    localparam logic [7:0]  CMD_NOMINAL = 8'h21;
    // Reset values
    localparam logic [15:0] RST_CEILING = 16'h08FC;
    localparam logic [15:0] RST_MARG_HI = 16'h0640;
    localparam logic [15:0] RST_MARG_LO = 16'h00FA;
    localparam logic [15:0] RST_SLEW    = 16'h0064;
    localparam logic [15:0] RST_DROOP   = 16'h0000;
    localparam logic [15:0] RST_FLOOR   = 16'h0000;
    localparam logic [15:0] RST_OV      = 16'h076C;
    localparam logic [15:0] RST_NOMINAL = 16'h0384;
    // Operation select codes
    localparam logic [1:0]  OP_NOMINAL  = 2'h0;
    localparam logic [1:0]  OP_MARG_LO  = 2'h1;
    localparam logic [1:0]  OP_MARG_HI  = 2'h2;
endpackage : vout_bank_pkg

// *** vout_limit_margin_command_bank.sv ***
// Paged output-target limit, margin, slew, droop and overvoltage command bank
`timescale 1ns/1ps
`default_nettype none
module vout_limit_margin_command_bank (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        page,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        commit_pending_config,
    input  wire logic [1:0]  op_sel_0,
    input  wire logic [1:0]  op_sel_1,
    input  wire logic [15:0] vout_sense_0,
    input  wire logic [15:0] vout_sense_1,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_rvalid,
    output logic             cmd_unsupported,
    output logic      [15:0] vref_target_0,
    output logic      [15:0] vref_target_1,
    output logic      [15:0] slew_rate_0,
    output logic      [15:0] slew_rate_1,
    output logic      [15:0] droop_slope_0,
    output logic      [15:0] droop_slope_1,
    output logic             ov_fault_0,
    output logic             ov_fault_1
);
    localparam int NW = 8;
    localparam logic [15:0] RST [NW] = '{
        vout_bank_pkg::RST_CEILING, vout_bank_pkg::RST_MARG_HI,
        vout_bank_pkg::RST_MARG_LO, vout_bank_pkg::RST_SLEW,
        vout_bank_pkg::RST_DROOP,   vout_bank_pkg::RST_FLOOR,
        vout_bank_pkg::RST_OV,      vout_bank_pkg::RST_NOMINAL};

    logic [NW-1:0] sel;
    logic          known;
    logic [15:0]   held [2][NW];
    logic [15:0]   live [2][NW];
    logic [15:0]   tgt  [2];
    logic [1:0]    op_sel [2];
    logic [15:0]   sense [2];

    // decode code to one of the paged words
    always_comb begin
        sel = '0;
        unique case (cmd_code)
            vout_bank_pkg::CMD_CEILING: sel[0] = 1'b1;
            vout_bank_pkg::CMD_MARG_HI: sel[1] = 1'b1;
            vout_bank_pkg::CMD_MARG_LO: sel[2] = 1'b1;
            vout_bank_pkg::CMD_SLEW:    sel[3] = 1'b1;
            vout_bank_pkg::CMD_DROOP:   sel[4] = 1'b1;
            vout_bank_pkg::CMD_FLOOR:   sel[5] = 1'b1;
            vout_bank_pkg::CMD_OV:      sel[6] = 1'b1;
            vout_bank_pkg::CMD_NOMINAL: sel[7] = 1'b1;
            default:                    sel = '0;
        endcase
        known = |sel;
    end

    assign op_sel[0] = op_sel_0;
    assign op_sel[1] = op_sel_1;
    assign sense[0]  = vout_sense_0;
    assign sense[1]  = vout_sense_1;

    genvar p, w;
    generate
        for (p = 0; p < vout_bank_pkg::PAGES; p++) begin : g_page
            for (w = 0; w < NW; w++) begin : g_word
                // slew, droop and OV are staged until commit
                paged_word #(.RESET_VALUE(RST[w])) u_word (
                    .mclk    (mclk),
                    .reset   (reset),
                    .wr_en   (cmd_wr && sel[w] && (page == 1'(p))),
                    .wr_data (cmd_wdata),
                    .commit  ((w == 3 || w == 4 || w == 6) ? commit_pending_config : 1'b1),
                    .held    (held[p][w]),
                    .live    (live[p][w])
                );
            end
            // clamp selected target, limits act at once
            target_clamp u_clamp (
                .op_sel    (op_sel[p]),
                .nominal   (held[p][7]),
                .marg_hi   (held[p][1]),
                .marg_lo   (held[p][2]),
                .floor_v   (held[p][5]),
                .ceiling_v (held[p][0]),
                .target    (tgt[p])
            );
        end
    endgenerate

    // Registered outputs
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic        unsup_reg;
    logic        unsup_next;
    logic [15:0] vref_reg [2];
    logic [15:0] vref_next [2];
    logic [15:0] slew_reg [2];
    logic [15:0] slew_next [2];
    logic [15:0] droop_reg [2];
    logic [15:0] droop_next [2];
    logic        ov_reg [2];
    logic        ov_next [2];
    logic [15:0] rd_word;

    always_comb begin
        rd_word = '0;
        for (int i = 0; i < NW; i++) begin
            if (sel[i]) begin
                rd_word = held[page][i];
            end
        end
        rdata_next  = (cmd_rd && known) ? rd_word : rdata_reg;
        rvalid_next = cmd_rd && known;
        unsup_next  = (cmd_rd || cmd_wr) && !known;
        for (int i = 0; i < 2; i++) begin
            vref_next[i]  = tgt[i];
            // committed slew and droop drive the loop
            slew_next[i]  = live[i][3];
            droop_next[i] = live[i][4];
            ov_next[i]    = sense[i] > live[i][6];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            unsup_reg  <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                vref_reg[i]  <= vout_bank_pkg::RST_NOMINAL;
                slew_reg[i]  <= vout_bank_pkg::RST_SLEW;
                droop_reg[i] <= vout_bank_pkg::RST_DROOP;
                ov_reg[i]    <= 1'b0;
            end
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            unsup_reg  <= unsup_next;
            for (int i = 0; i < 2; i++) begin
                vref_reg[i]  <= vref_next[i];
                slew_reg[i]  <= slew_next[i];
                droop_reg[i] <= droop_next[i];
                ov_reg[i]    <= ov_next[i];
            end
        end
    end

    assign cmd_rdata       = rdata_reg;
    assign cmd_rvalid      = rvalid_reg;
    assign cmd_unsupported = unsup_reg;
    assign vref_target_0   = vref_reg[0];
    assign vref_target_1   = vref_reg[1];
    assign slew_rate_0     = slew_reg[0];
    assign slew_rate_1     = slew_reg[1];
    assign droop_slope_0   = droop_reg[0];
    assign droop_slope_1   = droop_reg[1];
    assign ov_fault_0      = ov_reg[0];
    assign ov_fault_1      = ov_reg[1];

    // Reference path: vref is registered, so it answers to the words one edge back
    // ceiling on page 0
    a_ceiling_page0: assert property (
        @(posedge mclk) disable iff (reset)
        vref_target_0 <= $past(held[0][0]))
        else $error("target above ceiling on page 0");

    a_ceiling_page1: assert property (
        @(posedge mclk) disable iff (reset)
        vref_target_1 <= $past(held[1][0]))
        else $error("target above ceiling on page 1");

    // floor on page 0; an inverted window is settled by the ceiling
    a_floor_page0: assert property (
        @(posedge mclk) disable iff (reset)
        ($past(held[0][5]) <= $past(held[0][0])) |-> vref_target_0 >= $past(held[0][5]))
        else $error("target below floor on page 0");

    a_floor_page1: assert property (
        @(posedge mclk) disable iff (reset)
        ($past(held[1][5]) <= $past(held[1][0])) |-> vref_target_1 >= $past(held[1][5]))
        else $error("target below floor on page 1");

    a_margin_high: assert property (
        @(posedge mclk) disable iff (reset)
        (op_sel_0 == vout_bank_pkg::OP_MARG_HI && held[0][1] <= held[0][0] && held[0][1] >= held[0][5])
        |=> vref_target_0 == $past(held[0][1]))
        else $error("margin high not used");

    a_margin_low: assert property (
        @(posedge mclk) disable iff (reset)
        (op_sel_0 == vout_bank_pkg::OP_MARG_LO && held[0][2] <= held[0][0] && held[0][2] >= held[0][5])
        |=> vref_target_0 == $past(held[0][2]))
        else $error("margin low not used");

    a_margin_low_page1: assert property (
        @(posedge mclk) disable iff (reset)
        (op_sel_1 == vout_bank_pkg::OP_MARG_LO && held[1][2] <= held[1][0] && held[1][2] >= held[1][5])
        |=> vref_target_1 == $past(held[1][2]))
        else $error("margin low not used on page 1");

    a_nominal_used: assert property (
        @(posedge mclk) disable iff (reset)
        (op_sel_0 == vout_bank_pkg::OP_NOMINAL && held[0][7] <= held[0][0] && held[0][7] >= held[0][5])
        |=> vref_target_0 == $past(held[0][7]))
        else $error("nominal not used");

    a_nominal_page1: assert property (
        @(posedge mclk) disable iff (reset)
        (op_sel_1 == vout_bank_pkg::OP_NOMINAL && held[1][7] <= held[1][0] && held[1][7] >= held[1][5])
        |=> vref_target_1 == $past(held[1][7]))
        else $error("nominal not used on page 1");

    // Staging: a written slew, droop or threshold must not move the loop before commit
    // slew waits for commit
    a_slew_staged: assert property (
        @(posedge mclk) disable iff (reset)
        (!commit_pending_config && !$past(commit_pending_config)) |=> $stable(slew_rate_0))
        else $error("slew changed without commit");

    a_droop_staged: assert property (
        @(posedge mclk) disable iff (reset)
        (!commit_pending_config && !$past(commit_pending_config)) |=> $stable(droop_slope_1))
        else $error("droop changed without commit");

    a_commit_slew: assert property (
        @(posedge mclk) disable iff (reset)
        commit_pending_config |=> live[0][3] == $past(held[0][3]))
        else $error("commit did not load slew");

    a_commit_page1: assert property (
        @(posedge mclk) disable iff (reset)
        commit_pending_config |=> live[1][6] == $past(held[1][6]))
        else $error("commit did not load threshold on page 1");

    a_ov_tracks: assert property (
        @(posedge mclk) disable iff (reset)
        (vout_sense_0 > live[0][6]) |=> ov_fault_0)
        else $error("overvoltage not flagged");

    a_ov_clears: assert property (
        @(posedge mclk) disable iff (reset)
        !(vout_sense_0 > live[0][6]) |=> !ov_fault_0)
        else $error("overvoltage flagged at or below threshold");

    a_ov_page1: assert property (
        @(posedge mclk) disable iff (reset)
        (vout_sense_1 > live[1][6]) |=> ov_fault_1)
        else $error("overvoltage not flagged on page 1");

    // Command port: valid and unsupported are registered one-cycle pulses; read data holds its last value
    // read returns word
    a_read_back: assert property (
        @(posedge mclk) disable iff (reset)
        (cmd_rd && sel[0]) |=> (cmd_rvalid && cmd_rdata == $past(held[page][0])))
        else $error("bad read data");

    a_read_pulse: assert property (
        @(posedge mclk) disable iff (reset)
        cmd_rvalid == $past(cmd_rd && known))
        else $error("read valid not a single pulse after a known read");

    a_unsup_pulse: assert property (
        @(posedge mclk) disable iff (reset)
        cmd_unsupported == $past((cmd_rd || cmd_wr) && !known))
        else $error("unsupported flag wrong");

    a_rdata_holds: assert property (
        @(posedge mclk) disable iff (reset)
        !$past(cmd_rd && known) |-> $stable(cmd_rdata))
        else $error("read data moved without a read");

    a_page_isolated: assert property (
        @(posedge mclk) disable iff (reset)
        (cmd_wr && !page) |=> $stable(held[1][0]))
        else $error("page 0 write reached page 1");
endmodule : vout_limit_margin_command_bank
`default_nettype wire
